/* tkcs_engine.sv */
// touch key two-tier confirmation and scan sleep sequencer
`timescale 1ns/1ps
`include "tkcs_map.svh"
module tkcs_engine
    import tkcs_pkg::*;
#(
    parameter int TICK_CYCLES = `TKCS_TICK_CYCLES
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic acq_done_in,
    input wire logic acq_above_in,
    input wire logic host_start_in,
    input wire logic cal_req_in,
    input wire logic [15:0] sleep_interval_in,
    input wire logic cfg_we_in,
    input wire logic [4:0] cfg_key_in,
    input wire logic [7:0] cfg_quick_lim_in,
    input wire logic [7:0] cfg_scan_lim_in,
    input wire logic cfg_key_en_in,
    output logic acq_req_out,
    output logic [4:0] acq_key_out,
    output logic acq_cal_out,
    output logic [23:0] key_touched_out,
    output logic touch_event_out,
    output logic scan_done_out,
    output logic sleeping_out
);
    tkcs_mem_if mi();

    tkcs_key_mem u_mem (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .m(mi.mem)
    );

    tkcs_state_t state_r;
    tkcs_key_t key_r;
    tkcs_cnt_t q_cnt_r;
    tkcs_cnt_t qlim_r;
    tkcs_cnt_t slim_r;
    tkcs_cnt_t s_cnt_r;
    logic [23:0] touched_r;
    logic cal_scan_r;
    logic cal_pend_r;
    logic host_pend_r;
    logic scan_act_r;
    logic event_r;
    logic done_r;
    logic [17:0] div_r;
    logic tick;
    logic [15:0] slp_cnt_r;
    logic wake;
    logic last_scan_idle;
    logic sample;
    logic quick_hit;
    logic scan_hit;
    logic fail;
    tkcs_cnt_t q_nxt;
    tkcs_cnt_t s_nxt;

    // a limit of zero would be met on the first sample; treat it as one
    function automatic tkcs_cnt_t lim_eff(input tkcs_cnt_t lim);
        lim_eff = (lim == 8'h00) ? 8'h01 : lim;
    endfunction

    assign sample = (state_r == TKCS_WAIT) && acq_done_in && !cal_scan_r;
    assign q_nxt = q_cnt_r + 8'h01;
    assign s_nxt = (s_cnt_r == 8'hff) ? s_cnt_r : s_cnt_r + 8'h01;
    assign quick_hit = sample && acq_above_in &&
        (q_nxt >= lim_eff(qlim_r));
    assign scan_hit = quick_hit && (s_nxt >= lim_eff(slim_r));
    assign fail = sample && !acq_above_in;
    assign last_scan_idle = !scan_act_r && !host_pend_r && !cal_pend_r;
    assign wake = host_start_in || cal_req_in ||
        (tick && (slp_cnt_r + 16'h0001 >= sleep_interval_in));

    // sleep timebase: one enable pulse per sleep unit
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r <= 18'h00000;
        end else if (state_r != TKCS_SLEEP || div_r ==
            18'(TICK_CYCLES - 1)) begin
            div_r <= 18'h00000;
        end else begin
            div_r <= div_r + 18'h00001;
        end
    end
    assign tick = (state_r == TKCS_SLEEP) &&
        (div_r == 18'(TICK_CYCLES - 1));

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slp_cnt_r <= 16'h0000;
        end else if (state_r != TKCS_SLEEP) begin
            slp_cnt_r <= 16'h0000;
        end else if (tick) begin
            slp_cnt_r <= slp_cnt_r + 16'h0001;
        end
    end

    // scan sequencer
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= TKCS_READ;
            key_r <= 5'h00;
        end else begin
            case (state_r)
                TKCS_SLEEP: begin
                    if (wake) begin
                        state_r <= TKCS_READ;
                        key_r <= 5'h00;
                    end
                end
                TKCS_READ: begin
                    state_r <= TKCS_LOOK;
                end
                TKCS_LOOK: begin
                    if (!mi.rd_en) begin
                        state_r <= TKCS_NEXT;
                    end else begin
                        state_r <= TKCS_REQ;
                    end
                end
                TKCS_REQ: begin
                    state_r <= TKCS_WAIT;
                end
                TKCS_WAIT: begin
                    if (acq_done_in) begin
                        if (cal_scan_r || quick_hit || fail) begin
                            state_r <= TKCS_NEXT;
                        end else begin
                            state_r <= TKCS_REQ;
                        end
                    end
                end
                TKCS_NEXT: begin
                    if (key_r == `TKCS_LAST_KEY) begin
                        state_r <= TKCS_END;
                    end else begin
                        key_r <= key_r + 5'h01;
                        state_r <= TKCS_READ;
                    end
                end
                TKCS_END: begin
                    key_r <= 5'h00;
                    if (last_scan_idle) begin
                        state_r <= TKCS_SLEEP;
                    end else begin
                        state_r <= TKCS_READ;
                    end
                end
                default: begin
                    state_r <= TKCS_SLEEP;
                end
            endcase
        end
    end

    // per-visit counters; the quick counter only lives for one key visit
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_cnt_r <= 8'h00;
            qlim_r <= 8'h00;
            slim_r <= 8'h00;
            s_cnt_r <= 8'h00;
        end else if (state_r == TKCS_LOOK) begin
            q_cnt_r <= 8'h00;
            qlim_r <= mi.rd_qlim;
            slim_r <= mi.rd_slim;
            s_cnt_r <= mi.rd_cnt;
        end else if (fail) begin
            q_cnt_r <= 8'h00;
        end else if (sample && !quick_hit) begin
            q_cnt_r <= q_nxt;
        end
    end

    // scan counter write-back: at most one per key visit, so once a scan
    always_comb begin
        mi.rd_key = key_r;
        mi.wr_key = key_r;
        mi.wr_en = quick_hit || fail || (state_r == TKCS_WAIT &&
            acq_done_in && cal_scan_r);
        mi.wr_cnt = 8'h00;
        if (quick_hit) begin
            mi.wr_cnt = s_nxt;
        end
    end

    assign mi.cfg_we = cfg_we_in;
    assign mi.cfg_key = cfg_key_in;
    assign mi.cfg_qlim = cfg_quick_lim_in;
    assign mi.cfg_slim = cfg_scan_lim_in;
    assign mi.cfg_en = cfg_key_en_in;

    // touch state; release is taken on the first sample below threshold
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            touched_r <= 24'h000000;
            event_r <= 1'b0;
        end else begin
            event_r <= 1'b0;
            if (scan_hit && !touched_r[key_r]) begin
                touched_r[key_r] <= 1'b1;
                event_r <= 1'b1;
            end else if (fail && touched_r[key_r]) begin
                touched_r[key_r] <= 1'b0;
                event_r <= 1'b1;
            end
        end
    end

    // activity seen in this scan; a set in the end cycle carries over
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scan_act_r <= 1'b0;
        end else if (event_r || (state_r == TKCS_LOOK &&
            touched_r[key_r])) begin
            scan_act_r <= 1'b1;
        end else if (state_r == TKCS_END) begin
            scan_act_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            host_pend_r <= 1'b0;
        end else if (host_start_in && state_r != TKCS_SLEEP) begin
            host_pend_r <= 1'b1;
        end else if (state_r == TKCS_END) begin
            host_pend_r <= 1'b0;
        end
    end

    // calibration runs as one whole scan of its own
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cal_pend_r <= 1'b0;
            cal_scan_r <= 1'b0;
        end else begin
            // a request that wakes the engine is served by the wake scan
            if (cal_req_in && state_r != TKCS_SLEEP) begin
                cal_pend_r <= 1'b1;
            end else if (state_r == TKCS_END) begin
                cal_pend_r <= 1'b0;
            end
            if (state_r == TKCS_END || state_r == TKCS_SLEEP) begin
                cal_scan_r <= cal_pend_r || cal_req_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == TKCS_END);
        end
    end

    assign acq_req_out = (state_r == TKCS_REQ);
    assign acq_key_out = key_r;
    assign acq_cal_out = cal_scan_r;
    assign key_touched_out = touched_r;
    assign touch_event_out = event_r;
    assign scan_done_out = done_r;
    assign sleeping_out = (state_r == TKCS_SLEEP);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    quick_restart_a: assert property (fail |=> q_cnt_r == 8'h00)
        else $error("quick counter not cleared on miss");
    quick_adv_a: assert property (sample && acq_above_in && !quick_hit
        |=> q_cnt_r == $past(q_cnt_r) + 8'h01 && state_r == TKCS_REQ)
        else $error("quick counter did not advance with burst");
    scan_fail_a: assert property (fail |-> mi.wr_en
        && mi.wr_cnt == 8'h00)
        else $error("scan counter not cleared on quick failure");
    scan_adv_a: assert property (quick_hit |-> mi.wr_en
        && (s_cnt_r != 8'hff && mi.wr_cnt == s_cnt_r + 8'h01
        || s_cnt_r == 8'hff && mi.wr_cnt == 8'hff))
        else $error("scan counter did not advance");
    touch_decl_a: assert property (scan_hit && !touched_r[key_r]
        |=> touched_r[$past(key_r)] && event_r)
        else $error("key not declared touched");
    once_visit_a: assert property (mi.wr_en |=> state_r == TKCS_NEXT
        ##1 !mi.wr_en)
        else $error("scan counter written twice in a visit");
    sleep_block_a: assert property (state_r == TKCS_END
        && scan_act_r |=> state_r == TKCS_READ && key_r == 5'h00)
        else $error("slept after activity");
    host_wake_a: assert property (state_r == TKCS_SLEEP
        && host_start_in |=> state_r == TKCS_READ)
        else $error("host start did not wake");
    skip_key_a: assert property (state_r == TKCS_LOOK && !mi.rd_en
        |=> state_r == TKCS_NEXT ##1 !acq_req_out)
        else $error("disabled key acquired");

    touch_cov: cover property (scan_hit && !touched_r[key_r]);
    timed_wake_cov: cover property (state_r == TKCS_SLEEP && tick && wake);
    host_wake_cov: cover property (state_r == TKCS_SLEEP && host_start_in);
    cal_scan_cov: cover property (state_r == TKCS_END && cal_scan_r);
endmodule

/* tkcs_map.svh */
// constants for touch key confirmation and sleep control
// Notes on behaviour
// - each key's confirmation count rises on every acquisition above threshold; here the stored scan counter rises once per visit, on a quick hit
// - an acquisition not above threshold clears that key's count to zero
// - each key has an inner quick counter and an outer scan counter
// - quick counter bursts repeat on one key before the next key is sampled
// - each key has its own quick counter limit in setup storage
// - scan counter advances when quick counter reaches its limit
// - quick counter failure also clears the key's scan counter
// - scan counter reaching its per-key limit declares the key touched
// - scan counter advances at most once per full matrix scan
// - idle device sleeps, wakes periodically, scans, sleeps again
// - the sleep interval before automatic wake is configurable
// - host communication during sleep wakes the device for service and a scan
// - every wake performs at least one full matrix scan before sleeping
// - activity at scan end forces another full scan before sleep retry
// - no sleep if any key showed a touch event in the last scan
// - calibration takes one full scan; disabled keys are skipped
`ifndef TKCS_MAP_SVH
`define TKCS_MAP_SVH
`define TKCS_NUM_KEYS 24
`define TKCS_LAST_KEY 5'h17
`define TKCS_CLK_MHZ 200
`define TKCS_SLEEP_UNIT_US 1000
`define TKCS_TICK_CYCLES (`TKCS_SLEEP_UNIT_US * `TKCS_CLK_MHZ)
`define TKCS_QLIM_RST 8'h02
`define TKCS_SLIM_RST 8'h02
`endif

/* tkcs_pkg.sv */
// types shared by the touch key confirmation and sleep logic
package tkcs_pkg;
    typedef logic [4:0] tkcs_key_t;
    typedef logic [7:0] tkcs_cnt_t;
    typedef enum logic [2:0] {
        TKCS_SLEEP,
        TKCS_READ,
        TKCS_LOOK,
        TKCS_REQ,
        TKCS_WAIT,
        TKCS_NEXT,
        TKCS_END
    } tkcs_state_t;
endpackage

/* tkcs_mem_if.sv */
// per-key setup and counter storage port
`timescale 1ns/1ps
interface tkcs_mem_if;
    import tkcs_pkg::*;
    tkcs_key_t rd_key;
    tkcs_cnt_t rd_qlim;
    tkcs_cnt_t rd_slim;
    logic rd_en;
    tkcs_cnt_t rd_cnt;
    logic wr_en;
    tkcs_key_t wr_key;
    tkcs_cnt_t wr_cnt;
    logic cfg_we;
    tkcs_key_t cfg_key;
    tkcs_cnt_t cfg_qlim;
    tkcs_cnt_t cfg_slim;
    logic cfg_en;
    modport engine(output rd_key, input rd_qlim, input rd_slim,
        input rd_en, input rd_cnt, output wr_en, output wr_key,
        output wr_cnt, output cfg_we, output cfg_key, output cfg_qlim,
        output cfg_slim, output cfg_en);
    modport mem(input rd_key, output rd_qlim, output rd_slim,
        output rd_en, output rd_cnt, input wr_en, input wr_key,
        input wr_cnt, input cfg_we, input cfg_key, input cfg_qlim,
        input cfg_slim, input cfg_en);
endinterface

/* tkcs_key_mem.sv */
// per-key setup limits, enables and scan counters
`timescale 1ns/1ps
`include "tkcs_map.svh"
module tkcs_key_mem
    import tkcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    tkcs_mem_if.mem m
);
    tkcs_cnt_t qlim_r [`TKCS_NUM_KEYS];
    tkcs_cnt_t slim_r [`TKCS_NUM_KEYS];
    tkcs_cnt_t cnt_r [`TKCS_NUM_KEYS];
    logic [`TKCS_NUM_KEYS-1:0] en_r;

    // setup storage, one limit pair per key
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `TKCS_NUM_KEYS; i++) begin
                qlim_r[i] <= `TKCS_QLIM_RST;
                slim_r[i] <= `TKCS_SLIM_RST;
            end
            en_r <= '1;
        end else if (m.cfg_we && m.cfg_key <= `TKCS_LAST_KEY) begin
            qlim_r[m.cfg_key] <= m.cfg_qlim;
            slim_r[m.cfg_key] <= m.cfg_slim;
            en_r[m.cfg_key] <= m.cfg_en;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `TKCS_NUM_KEYS; i++) begin
                cnt_r[i] <= 8'h00;
            end
        end else if (m.wr_en && m.wr_key <= `TKCS_LAST_KEY) begin
            cnt_r[m.wr_key] <= m.wr_cnt;
        end
    end

    // registered read: data follows the key by one cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            m.rd_qlim <= 8'h00;
            m.rd_slim <= 8'h00;
            m.rd_en <= 1'b0;
            m.rd_cnt <= 8'h00;
        end else if (m.rd_key <= `TKCS_LAST_KEY) begin
            m.rd_qlim <= qlim_r[m.rd_key];
            m.rd_slim <= slim_r[m.rd_key];
            m.rd_en <= en_r[m.rd_key];
            m.rd_cnt <= cnt_r[m.rd_key];
        end
    end
endmodule

/* touch_key_confirm_and_sleep_tb.sv */
// self-checking bench for the touch key confirm and sleep engine
`timescale 1ns/1ps
module touch_key_confirm_and_sleep_tb;
    localparam int TICK = 4;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic acq_done_in = 1'b0;
    logic acq_above_in = 1'b0;
    logic host_start_in = 1'b0;
    logic cal_req_in = 1'b0;
    logic [15:0] sleep_interval_in = 16'h0002;
    logic cfg_we_in = 1'b0;
    logic [4:0] cfg_key_in = 5'h00;
    logic [7:0] cfg_quick_lim_in = 8'h02;
    logic [7:0] cfg_scan_lim_in = 8'h02;
    logic cfg_key_en_in = 1'b1;
    logic acq_req_out;
    logic [4:0] acq_key_out;
    logic acq_cal_out;
    logic [23:0] key_touched_out;
    logic touch_event_out;
    logic scan_done_out;
    logic sleeping_out;
    int bad_count = 0;
    int n_tests = 0;
    int ev_n = 0;
    logic [4:0] skip_k = 5'h1f;

    tkcs_engine #(.TICK_CYCLES(TICK)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .acq_done_in(acq_done_in), .acq_above_in(acq_above_in),
        .host_start_in(host_start_in), .cal_req_in(cal_req_in),
        .sleep_interval_in(sleep_interval_in), .cfg_we_in(cfg_we_in),
        .cfg_key_in(cfg_key_in), .cfg_quick_lim_in(cfg_quick_lim_in),
        .cfg_scan_lim_in(cfg_scan_lim_in), .cfg_key_en_in(cfg_key_en_in),
        .acq_req_out(acq_req_out), .acq_key_out(acq_key_out),
        .acq_cal_out(acq_cal_out), .key_touched_out(key_touched_out),
        .touch_event_out(touch_event_out), .scan_done_out(scan_done_out),
        .sleeping_out(sleeping_out));

    always #2.5 clk_in = ~clk_in;

    // event pulses last one cycle, so count them at every edge
    always @(posedge clk_in) begin
        if (touch_event_out === 1'b1) begin
            ev_n <= ev_n + 1;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timed_out(input string what);
        bad_count++;
        $display("[ERR] %s expected event seen timeout", what);
        tally_and_finish();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // answers one acquisition request; request may already be up on entry
    task automatic serve(input logic [4:0] k, input logic above,
                         input logic cal);
        int i;
        i = 0;
        while (acq_req_out !== 1'b1 && i < 60) begin
            tick(1);
            i++;
        end
        if (i == 60) timed_out("acq request");
        chk("acq key", acq_key_out, k);
        chk("cal flag", acq_cal_out, cal);
        tick(1);
        acq_done_in = 1'b1;
        acq_above_in = above;
        tick(1);
        acq_done_in = 1'b0;
    endtask

    // key 3 gets n_above hits then an optional miss, except in a cal scan; others one miss, skip_k none
    task automatic do_scan(input int n_above, input bit tail, input bit cal);
        int i;
        for (int k = 0; k < 24; k++) begin
            if (k[4:0] == skip_k) continue;
            if (cal) begin
                serve(k[4:0], 1'b0, 1'b1);
            end else if (k == 3) begin
                repeat (n_above) serve(5'h03, 1'b1, 1'b0);
                if (tail) serve(5'h03, 1'b0, 1'b0);
            end else begin
                serve(k[4:0], 1'b0, 1'b0);
            end
        end
        i = 0;
        while (scan_done_out !== 1'b1 && i < 60) begin
            tick(1);
            i++;
        end
        if (i == 60) timed_out("scan done");
        tick(2);
    endtask

    task automatic go_sleep;
        for (int j = 0; j < 4; j++) begin
            if (sleeping_out === 1'b1) break;
            do_scan(0, 1'b1, 1'b0);
        end
        chk("sleep reached", sleeping_out, 1'b1);
    endtask

    task automatic cfg(input logic [4:0] k, input logic [7:0] q,
                       input logic [7:0] s, input logic en);
        cfg_key_in = k;
        cfg_quick_lim_in = q;
        cfg_scan_lim_in = s;
        cfg_key_en_in = en;
        cfg_we_in = 1'b1;
        tick(1);
        cfg_we_in = 1'b0;
    endtask

    task automatic t_reset;
        chk("touched after reset", key_touched_out, 24'h000000);
        chk("awake after reset", sleeping_out, 1'b0);
        do_scan(0, 1'b1, 1'b0);
        chk("sleep after idle scan", sleeping_out, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_auto_wake;
        int n;
        n = 0;
        while (sleeping_out === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        // two ticks of TICK cycles; do_scan already spent two of them
        chk("sleep length", n, 2 * TICK - 2);
        do_scan(0, 1'b1, 1'b0);
        chk("sleep again", sleeping_out, 1'b1);
        $display("test auto wake done");
    endtask

    task automatic t_confirm;
        cfg(5'h03, 8'h03, 8'h02, 1'b1);
        host_start_in = 1'b1;
        tick(1);
        host_start_in = 1'b0;
        tick(1);
        chk("host wake", sleeping_out, 1'b0);
        do_scan(3, 1'b0, 1'b0);
        chk("one scan not touched", key_touched_out, 24'h000000);
        do_scan(2, 1'b1, 1'b0);
        do_scan(3, 1'b0, 1'b0);
        chk("outer reset by miss", key_touched_out, 24'h000000);
        do_scan(3, 1'b0, 1'b0);
        chk("touched key 3", key_touched_out, 24'h000008);
        chk("touch event", ev_n, 1);
        chk("no sleep on event", sleeping_out, 1'b0);
        do_scan(0, 1'b1, 1'b0);
        chk("released", key_touched_out, 24'h000000);
        chk("release event", ev_n, 2);
        chk("rescan on activity", sleeping_out, 1'b0);
        go_sleep();
        $display("test confirm done");
    endtask

    task automatic t_cal;
        cfg(5'h07, 8'h02, 8'h02, 1'b0);
        skip_k = 5'h07;
        cal_req_in = 1'b1;
        tick(1);
        cal_req_in = 1'b0;
        do_scan(0, 1'b1, 1'b1);
        chk("touched after cal", key_touched_out, 24'h000000);
        go_sleep();
        $display("test calibration done");
    endtask

    // second cycle of the strobe lands awake, so it is held as pending
    task automatic t_host_busy;
        host_start_in = 1'b1;
        tick(2);
        host_start_in = 1'b0;
        chk("host wake busy", sleeping_out, 1'b0);
        do_scan(0, 1'b1, 1'b0);
        chk("rescan after host", sleeping_out, 1'b0);
        go_sleep();
        $display("test host busy done");
    endtask

    initial begin
        #300000;
        timed_out("whole run");
    end

    initial begin
        tick(12);
        resetn_in = 1'b1;
        t_reset();
        t_auto_wake();
        t_confirm();
        t_cal();
        t_host_busy();
        tally_and_finish();
    end
endmodule
